// ===== rtl/gpio_cd_defs.svh
// Purpose: Register offsets, reset values and field positions for the port C/D block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Offsets are local choices, one aligned word per register
`ifndef GPIO_CD_DEFS_SVH
`define GPIO_CD_DEFS_SVH

// Register byte addresses
`define OFF_PORT_C_PIN_LEVELS    12'h000
`define OFF_PORT_C_OUTPUT_LATCH  12'h004
`define OFF_PORT_C_DIRECTION     12'h008
`define OFF_PORT_D_PIN_LEVELS    12'h00C
`define OFF_PORT_D_OUTPUT_LATCH  12'h010
`define OFF_PORT_D_DIRECTION     12'h014
`define OFF_PORT_E_DIRECTION     12'h018
`define OFF_PERIPH_CONFIG        12'h01C

// Reset values: port C/D pins all inputs, port E bits 0..2 inputs, latches clear
`define RST_DIRECTION            8'hFF
`define RST_LATCH                8'h00
`define RST_PORT_E_DIRECTION     8'h07
`define RST_PERIPH_CONFIG        8'h01

// Field positions
`define BIT_PARALLEL_SLAVE_ENABLE 4
`define BIT_SECOND_CHANNEL_SEL    0
`define BIT_PWM_MODE_LO           1

`endif

// ===== rtl/gpio_cd_pkg.sv
// Purpose: Types shared by the port C/D block
// Assumes: Included with gpio_cd_defs.svh for numbers
// Notes:   Types only
package gpio_cd_pkg;

   // Enhanced PWM output arrangement
   typedef enum logic [1:0]
   {
      PWM_SINGLE   = 2'b00,
      PWM_HALF     = 2'b01,
      PWM_FULL_FWD = 2'b10,
      PWM_FULL_REV = 2'b11
   } pwm_mode_t;

   // APB slave phase
   typedef enum logic [0:0]
   {
      BUS_IDLE   = 1'b0,
      BUS_ACCESS = 1'b1
   } bus_state_t;

endpackage

// ===== rtl/pin_drive.sv
// Purpose: Per-bit output mux and enable for one 8-bit port
// Assumes: Peripheral overrides already resolved into mask and data
// Notes:   Direction bit high means input (driver off)
`timescale 1ns/1ns
`default_nettype none

module pin_drive
(
   input  wire logic [7:0] i_latch,
   input  wire logic [7:0] i_direction,
   input  wire logic [7:0] i_ovr_en,
   input  wire logic [7:0] i_ovr_data,
   input  wire logic [7:0] i_ovr_oe,
   output logic      [7:0] o_out,
   output logic      [7:0] o_oe
);

   genvar b;

   // Peripheral owns a bit when its override is set, else latch and direction
   generate
      for (b = 0; b < 8; b++)
      begin : g_bit
         assign o_out[b] = i_ovr_en[b] ? i_ovr_data[b] : i_latch[b];
         assign o_oe[b]  = i_ovr_en[b] ? i_ovr_oe[b] : ~i_direction[b];
      end
   endgenerate

endmodule // pin_drive
`default_nettype wire

// ===== rtl/pin_sync.sv
// Purpose: Two-stage synchroniser for an 8-bit group of pin levels
// Assumes: Pins asynchronous to i_clk
// Notes:   First stage feeds only the second
`timescale 1ns/1ns
`default_nettype none

module pin_sync
(
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic [7:0] i_pins,
   output logic      [7:0] o_levels
);

   logic [7:0] stage1;

   // Two flops so a metastable first stage never reaches software
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         stage1   <= 8'h00;
         o_levels <= 8'h00;
      end
      else
      begin
         stage1   <= i_pins;
         o_levels <= stage1;
      end
   end

endmodule // pin_sync
`default_nettype wire

// ===== rtl/port_cd_io.sv
// Purpose: Port C upper bits and port D pin ownership, direction and latches
// Assumes: APB slave, zero wait states; peripherals supply their own enables
// Notes:   Serial and PWM waveform logic lives outside this block
//
// What this block does
// - Port C bit 5 output drives sync serial data out instead of latch
// - Async serial transmit drives port C bit 6 over latch when owned
// - Sync master clock output drives port C bit 6 over latch
// - Sync slave mode feeds port C bit 6 input as external clock
// - Port C bit 7 input level routes to async receive data
// - Sync transmit data drives port C bit 7 over latch
// - Port C latch register accesses stored latch, not pins
// - Port D has eight pins each with own direction
// - Port D direction one makes pin input, driver off
// - Port D direction zero drives latch bit onto pin
// - Port D latch read-modify-write uses latched value
// - PWM outputs B, C, D take over three port D pins in full-bridge modes; half-bridge takes only B on bit 5
// - After reset, PWM-shared pins are digital inputs
// - Parallel slave enable, port E direction bit 4, makes port D slave port
// - Dual or quad PWM disables parallel slave port functions
// - Second channel goes to port C bit 1 if select set, else port B bit 3
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_cd_defs.svh"

module port_cd_io
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   // APB
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Port C pins, bits 7..5 and bit 1 meaningful
   input  wire logic [7:0]  i_port_c_pins,
   output logic      [7:0]  o_port_c_out,
   output logic      [7:0]  o_port_c_oe,
   // Port D pins
   input  wire logic [7:0]  i_port_d_pins,
   output logic      [7:0]  o_port_d_out,
   output logic      [7:0]  o_port_d_oe,
   // Sync serial peripheral
   input  wire logic        i_sync_serial_data_out,
   // Universal serial peripheral
   input  wire logic        i_usart_enable,
   input  wire logic        i_usart_sync,
   input  wire logic        i_usart_master,
   input  wire logic        i_usart_sync_tx,
   input  wire logic        i_usart_tx,
   input  wire logic        i_sync_serial_clock_out,
   input  wire logic        i_sync_serial_data_tx,
   output logic             o_sync_serial_clock_in,
   output logic             o_usart_rx,
   // Enhanced PWM
   input  wire logic        i_pwm_enable,
   input  wire logic [2:0]  i_pwm_bcd,
   // Parallel slave port
   input  wire logic [7:0]  i_psp_read_data,
   input  wire logic        i_psp_read_oe,
   output logic             o_parallel_slave_port_active,
   output logic             o_psp_ttl_select,
   // Second channel routing
   input  wire logic        i_second_channel_out,
   input  wire logic        i_second_channel_oe,
   output logic             o_second_channel_on_c1,
   output logic             o_port_b_bit3_out,
   output logic             o_port_b_bit3_oe
);

   ////////////////////////////////////////////////////////////////////////
   // Registers

   logic [7:0] port_c_output_latch;
   logic [7:0] port_c_direction;
   logic [7:0] port_d_output_latch;
   logic [7:0] port_d_direction;
   logic [7:0] port_e_direction;
   logic [7:0] periph_config;
   logic [7:0] port_c_levels;
   logic [7:0] port_d_levels;

   gpio_cd_pkg::pwm_mode_t pwm_mode;

   // Two-flop capture of the pins for reads
   pin_sync u_sync_c
   (
      .i_clk    (i_clk),
      .i_rst_n  (i_rst_n),
      .i_pins   (i_port_c_pins),
      .o_levels (port_c_levels)
   );

   pin_sync u_sync_d
   (
      .i_clk    (i_clk),
      .i_rst_n  (i_rst_n),
      .i_pins   (i_port_d_pins),
      .o_levels (port_d_levels)
   );

   ////////////////////////////////////////////////////////////////////////
   // APB decode; single-cycle access, no wait states

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction

   wire wr_en    = psel & penable & pwrite;
   wire wr_c_pin = wr_en & hit(paddr, `OFF_PORT_C_PIN_LEVELS);
   wire wr_c_lat = wr_en & hit(paddr, `OFF_PORT_C_OUTPUT_LATCH);
   wire wr_c_dir = wr_en & hit(paddr, `OFF_PORT_C_DIRECTION);
   wire wr_d_pin = wr_en & hit(paddr, `OFF_PORT_D_PIN_LEVELS);
   wire wr_d_lat = wr_en & hit(paddr, `OFF_PORT_D_OUTPUT_LATCH);
   wire wr_d_dir = wr_en & hit(paddr, `OFF_PORT_D_DIRECTION);
   wire wr_e_dir = wr_en & hit(paddr, `OFF_PORT_E_DIRECTION);
   wire wr_cfg   = wr_en & hit(paddr, `OFF_PERIPH_CONFIG);

   wire mapped = hit(paddr, `OFF_PORT_C_PIN_LEVELS) | hit(paddr, `OFF_PORT_C_OUTPUT_LATCH)
               | hit(paddr, `OFF_PORT_C_DIRECTION)  | hit(paddr, `OFF_PORT_D_PIN_LEVELS)
               | hit(paddr, `OFF_PORT_D_OUTPUT_LATCH) | hit(paddr, `OFF_PORT_D_DIRECTION)
               | hit(paddr, `OFF_PORT_E_DIRECTION)  | hit(paddr, `OFF_PERIPH_CONFIG);

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // Read mux: pin registers give synchronised levels, latch registers the latch
   logic [7:0] rd_byte;
   always_comb
   begin
      case (paddr)
         `OFF_PORT_C_PIN_LEVELS:   rd_byte = port_c_levels;
         `OFF_PORT_C_OUTPUT_LATCH: rd_byte = port_c_output_latch;
         `OFF_PORT_C_DIRECTION:    rd_byte = port_c_direction;
         `OFF_PORT_D_PIN_LEVELS:   rd_byte = port_d_levels;
         `OFF_PORT_D_OUTPUT_LATCH: rd_byte = port_d_output_latch;
         `OFF_PORT_D_DIRECTION:    rd_byte = port_d_direction;
         `OFF_PORT_E_DIRECTION:    rd_byte = port_e_direction;
         `OFF_PERIPH_CONFIG:       rd_byte = periph_config;
         default:                  rd_byte = 8'h00;
      endcase
   end
   assign prdata = {24'h000000, rd_byte};

   ////////////////////////////////////////////////////////////////////////
   // Register writes; both data and latch addresses land in the latch

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         port_c_output_latch <= `RST_LATCH;
         port_d_output_latch <= `RST_LATCH;
      end
      else
      begin
         if (wr_c_pin | wr_c_lat)
            port_c_output_latch <= pwdata[7:0];
         if (wr_d_pin | wr_d_lat)
            port_d_output_latch <= pwdata[7:0];
      end
   end

   // Port C/D directions reset to all-input so shared pins come up as inputs; port E direction to 0x07
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         port_c_direction <= `RST_DIRECTION;
         port_d_direction <= `RST_DIRECTION;
         port_e_direction <= `RST_PORT_E_DIRECTION;
         periph_config    <= `RST_PERIPH_CONFIG;
      end
      else
      begin
         if (wr_c_dir)
            port_c_direction <= pwdata[7:0];
         if (wr_d_dir)
            port_d_direction <= pwdata[7:0];
         if (wr_e_dir)
            port_e_direction <= pwdata[7:0];
         if (wr_cfg)
            periph_config <= pwdata[7:0];
      end
   end

   assign pwm_mode = gpio_cd_pkg::pwm_mode_t'(periph_config[`BIT_PWM_MODE_LO +: 2]);

   ////////////////////////////////////////////////////////////////////////
   // Port C ownership for bits 5..7

   wire usart_async  = i_usart_enable & ~i_usart_sync;
   wire usart_smastr = i_usart_enable & i_usart_sync & i_usart_master;
   wire usart_sslave = i_usart_enable & i_usart_sync & ~i_usart_master;
   wire c5_sdo_own   = ~port_c_direction[5];
   wire c6_own       = usart_async | usart_smastr;
   wire c6_data      = usart_async ? i_usart_tx : i_sync_serial_clock_out;
   wire c6_oe        = usart_smastr | ~port_c_direction[6];
   wire c7_own       = i_usart_enable & i_usart_sync & i_usart_sync_tx;

   // Second channel pin select
   wire ch2_on_c1 = periph_config[`BIT_SECOND_CHANNEL_SEL];

   wire [7:0] c_ovr_en   = {c7_own, c6_own, c5_sdo_own, 3'b000, ch2_on_c1, 1'b0};
   wire [7:0] c_ovr_data = {i_sync_serial_data_tx, c6_data, i_sync_serial_data_out,
                            3'b000, i_second_channel_out, 1'b0};
   wire [7:0] c_ovr_oe   = {1'b1, c6_oe, 1'b1, 3'b000, i_second_channel_oe, 1'b0};

   pin_drive u_drive_c
   (
      .i_latch     (port_c_output_latch),
      .i_direction (port_c_direction),
      .i_ovr_en    (c_ovr_en),
      .i_ovr_data  (c_ovr_data),
      .i_ovr_oe    (c_ovr_oe),
      .o_out       (o_port_c_out),
      .o_oe        (o_port_c_oe)
   );

   // Inputs to the serial peripheral come from synchronised levels
   assign o_sync_serial_clock_in = (usart_sslave & port_c_direction[6]) ? port_c_levels[6] : 1'b0;
   assign o_usart_rx             = port_c_direction[7] ? port_c_levels[7] : 1'b1;

   // Alternate second channel location
   assign o_second_channel_on_c1 = ch2_on_c1;
   assign o_port_b_bit3_out      = ch2_on_c1 ? 1'b0 : i_second_channel_out;
   assign o_port_b_bit3_oe       = ~ch2_on_c1 & i_second_channel_oe;

   ////////////////////////////////////////////////////////////////////////
   // Port D ownership: PWM beats parallel slave beats latch

   wire multi_pwm = i_pwm_enable & (pwm_mode != gpio_cd_pkg::PWM_SINGLE);
   wire psp_on    = port_e_direction[`BIT_PARALLEL_SLAVE_ENABLE] & ~multi_pwm;
   wire [7:0] pwm_own;

   // Half-bridge uses only B; full-bridge uses B, C and D
   assign pwm_own = {multi_pwm & pwm_mode != gpio_cd_pkg::PWM_HALF,
                     multi_pwm & pwm_mode != gpio_cd_pkg::PWM_HALF,
                     multi_pwm, 5'b00000};

   wire [7:0] d_ovr_en   = pwm_own | {8{psp_on}};
   wire [7:0] d_ovr_data = pwm_own[5] ? {i_pwm_bcd, i_psp_read_data[4:0]} : i_psp_read_data;
   wire [7:0] d_pwm_oe   = pwm_own & ~port_d_direction;
   wire [7:0] d_ovr_oe   = (pwm_own & d_pwm_oe) | (~pwm_own & {8{psp_on & i_psp_read_oe}});

   pin_drive u_drive_d
   (
      .i_latch     (port_d_output_latch),
      .i_direction (port_d_direction),
      .i_ovr_en    (d_ovr_en),
      .i_ovr_data  ({pwm_own[7] ? i_pwm_bcd[2] : d_ovr_data[7],
                     pwm_own[6] ? i_pwm_bcd[1] : d_ovr_data[6],
                     pwm_own[5] ? i_pwm_bcd[0] : d_ovr_data[5],
                     d_ovr_data[4:0]}),
      .i_ovr_oe    (d_ovr_oe),
      .o_out       (o_port_d_out),
      .o_oe        (o_port_d_oe)
   );

   assign o_parallel_slave_port_active = psp_on;
   assign o_psp_ttl_select             = psp_on;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   chk_d_dir_input: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (port_d_direction[0] & ~psp_on) |-> !o_port_d_oe[0])
      else $error("port D bit 0 driven while input");

   chk_d_latch_out: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (!port_d_direction[1] & ~psp_on) |-> (o_port_d_oe[1] && o_port_d_out[1] == port_d_output_latch[1]))
      else $error("port D bit 1 not driving latch");

   chk_latch_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      wr_d_pin |=> port_d_output_latch == $past(pwdata[7:0]))
      else $error("port D latch missed write");

   chk_c_latch_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (psel && paddr == `OFF_PORT_C_OUTPUT_LATCH) |-> prdata[7:0] == port_c_output_latch)
      else $error("port C latch read wrong");

   chk_d_pin_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (psel && paddr == `OFF_PORT_D_PIN_LEVELS) |-> prdata[7:0] == $past(i_port_d_pins, 2))
      else $error("port D pin read not synchronised level");

   chk_sdo_owns: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !port_c_direction[5] |-> o_port_c_out[5] == i_sync_serial_data_out)
      else $error("bit 5 not driven by serial data");

   chk_tx_owns: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      usart_async |-> o_port_c_out[6] == i_usart_tx)
      else $error("bit 6 not driven by transmit");

   chk_clk_master: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      usart_smastr |-> (o_port_c_oe[6] && o_port_c_out[6] == i_sync_serial_clock_out))
      else $error("bit 6 not driven by master clock");

   chk_rx_route: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      port_c_direction[7] |-> o_usart_rx == port_c_levels[7])
      else $error("receive input not routed");

   chk_psp_disable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_pwm_enable && pwm_mode != gpio_cd_pkg::PWM_SINGLE) |-> !(o_parallel_slave_port_active || o_psp_ttl_select))
      else $error("slave port active with multi PWM");

   chk_reset_inputs: assert property (@(posedge i_clk)
      $rose(i_rst_n) |-> o_port_d_oe[7:5] == 3'b000)
      else $error("PWM pins not inputs after reset");

endmodule // port_cd_io
`default_nettype wire

// ===== testbench/pin_partner.sv
// Purpose: External circuitry on the port C and port D pins
// Assumes: Bench sets the level each pin sees while the block releases it
// Notes:   Driven bits follow the block, released bits follow the bench
`timescale 1ns/1ns
`default_nettype none

module pin_partner
(
   input  wire logic [7:0] i_c_out,
   input  wire logic [7:0] i_c_oe,
   input  wire logic [7:0] i_d_out,
   input  wire logic [7:0] i_d_oe,
   input  wire logic [7:0] i_c_ext,
   input  wire logic [7:0] i_d_ext,
   output logic      [7:0] o_c_pins,
   output logic      [7:0] o_d_pins
);
   // Per-bit wire level; a driving block always wins, so no contention is modelled
   assign o_c_pins = (i_c_oe & i_c_out) | (~i_c_oe & i_c_ext);
   assign o_d_pins = (i_d_oe & i_d_out) | (~i_d_oe & i_d_ext);
endmodule // pin_partner
`default_nettype wire

// ===== testbench/port_cd_io_bench.sv
// Purpose: Self-checking bench for the port C/D pin block
// Assumes: Zero-wait APB slave, pin reads two edges late
// Notes:   Pin checks after settle sampled on the falling edge; bus reads at the pready edge
`timescale 1ns/1ns
`default_nettype none
`include "gpio_cd_defs.svh"

module port_cd_io_bench;
   logic        i_clk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr;
   logic [7:0]  c_pins, c_out, c_oe, d_pins, d_out, d_oe;
   logic [7:0]  c_ext = 8'h00, d_ext = 8'h00;
   logic        ssp_do = 1'b0, u_en = 1'b0, u_sync = 1'b0, u_master = 1'b0, u_stx = 1'b0, u_tx = 1'b0;
   logic        s_clk = 1'b0, s_dtx = 1'b0, pwm_en = 1'b0, psp_oe = 1'b0, ch2_out = 1'b0, ch2_oe = 1'b0;
   logic [2:0]  pwm_bcd = 3'h0;
   logic [7:0]  psp_rd = 8'h00;
   logic        clk_in, rx, psp_act, ttl, on_c1, b3_out, b3_oe;
   int          err_count = 0;
   int          comparisons = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and pin partner
   initial
   begin
      forever #5 i_clk = ~i_clk;
   end

   pin_partner pins_u (.i_c_out(c_out), .i_c_oe(c_oe), .i_d_out(d_out), .i_d_oe(d_oe),
                       .i_c_ext(c_ext), .i_d_ext(d_ext), .o_c_pins(c_pins), .o_d_pins(d_pins));

   port_cd_io dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .i_port_c_pins(c_pins), .o_port_c_out(c_out), .o_port_c_oe(c_oe),
      .i_port_d_pins(d_pins), .o_port_d_out(d_out), .o_port_d_oe(d_oe),
      .i_sync_serial_data_out(ssp_do), .i_usart_enable(u_en), .i_usart_sync(u_sync),
      .i_usart_master(u_master), .i_usart_sync_tx(u_stx), .i_usart_tx(u_tx),
      .i_sync_serial_clock_out(s_clk), .i_sync_serial_data_tx(s_dtx), .o_sync_serial_clock_in(clk_in),
      .o_usart_rx(rx), .i_pwm_enable(pwm_en), .i_pwm_bcd(pwm_bcd), .i_psp_read_data(psp_rd),
      .i_psp_read_oe(psp_oe), .o_parallel_slave_port_active(psp_act), .o_psp_ttl_select(ttl),
      .i_second_channel_out(ch2_out), .i_second_channel_oe(ch2_oe), .o_second_channel_on_c1(on_c1),
      .o_port_b_bit3_out(b3_out), .o_port_b_bit3_oe(b3_oe));

   ////////////////////////////////////////////////////////////////////////////
   // Verdict, comparison and bus tasks
   task automatic wrap_up();
      if (err_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; read data and error taken at the pready edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      @(posedge i_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
      @(posedge i_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge i_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50)
      begin
         err_count++;
         wrap_up();
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        er;
      xfer(1'b1, a, d, rd, er);
   endtask

   task automatic rc(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] rd;
      logic        er;
      xfer(1'b0, a, 32'h0, rd, er);
      chk(rd, exp);
      chk(32'(er), 32'(exp_err));
   endtask

   // Let launched updates and the pin synchroniser settle, then sample
   task automatic settle();
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (12) @(posedge i_clk);
      i_rst_n <= 1'b1;
      // Reset state of registers and drivers
      rc(`OFF_PORT_C_DIRECTION, 32'h000000FF, 1'b0);
      rc(`OFF_PORT_D_DIRECTION, 32'h000000FF, 1'b0);
      rc(`OFF_PORT_C_OUTPUT_LATCH, 32'h0, 1'b0);
      rc(`OFF_PORT_D_OUTPUT_LATCH, 32'h0, 1'b0);
      rc(`OFF_PORT_E_DIRECTION, 32'h00000007, 1'b0);
      rc(`OFF_PERIPH_CONFIG, 32'h00000001, 1'b0);
      chk(32'(d_oe), 32'h0);
      chk(32'(c_oe[7:5]), 32'h0);
      // Latch reads stored value while pins show something else
      c_ext <= 8'h5A;
      d_ext <= 8'hC3;
      wr(`OFF_PORT_C_OUTPUT_LATCH, 32'hFFFFFFA5);
      rc(`OFF_PORT_C_OUTPUT_LATCH, 32'h000000A5, 1'b0);
      wr(`OFF_PORT_D_OUTPUT_LATCH, 32'h0000003C);
      rc(`OFF_PORT_D_OUTPUT_LATCH, 32'h0000003C, 1'b0);
      rc(`OFF_PORT_D_PIN_LEVELS, 32'h000000C3, 1'b0);
      rc(`OFF_PORT_C_PIN_LEVELS, 32'h0000005A, 1'b0);
      wr(`OFF_PORT_D_PIN_LEVELS, 32'hABCDEF96);
      rc(`OFF_PORT_D_OUTPUT_LATCH, 32'h00000096, 1'b0);
      wr(`OFF_PORT_C_PIN_LEVELS, 32'h000000A1);
      rc(`OFF_PORT_C_OUTPUT_LATCH, 32'h000000A1, 1'b0);
      // Per-bit direction: upper nibble drives, lower nibble released
      wr(`OFF_PORT_D_DIRECTION, 32'h0000000F);
      settle();
      chk(32'(d_oe), 32'hF0);
      chk(32'(d_out[7:4]), 32'h9);
      rc(`OFF_PORT_D_PIN_LEVELS, 32'h00000093, 1'b0);
      // Port C bit 5 handed to the sync serial data output
      wr(`OFF_PORT_C_DIRECTION, 32'h000000DF);
      settle();
      chk(32'({c_oe[5], c_out[5]}), 32'h2);
      @(posedge i_clk);
      ssp_do <= 1'b1;
      settle();
      chk(32'(c_out[5]), 32'h1);
      // Async transmit, then sync master clock and sync transmit data
      wr(`OFF_PORT_C_DIRECTION, 32'h0000009F);
      u_en <= 1'b1;
      u_tx <= 1'b1;
      settle();
      chk(32'(c_out[6]), 32'h1);
      @(posedge i_clk);
      u_sync <= 1'b1;
      u_master <= 1'b1;
      u_tx <= 1'b0;
      s_clk <= 1'b1;
      u_stx <= 1'b1;
      settle();
      chk(32'(c_out[6]), 32'h1);
      chk(32'(c_out[7]), 32'h0);
      // Slave clock in on bit 6, receive data on bit 7
      wr(`OFF_PORT_C_DIRECTION, 32'h000000FF);
      u_master <= 1'b0;
      u_stx <= 1'b0;
      c_ext <= 8'h40;
      settle();
      chk(32'({clk_in, rx}), 32'h2);
      @(posedge i_clk);
      c_ext <= 8'h80;
      settle();
      chk(32'({clk_in, rx}), 32'h1);
      // Enhanced PWM takes D5..D7 in full mode, then only D5 in half mode
      wr(`OFF_PORT_D_DIRECTION, 32'h00000000);
      wr(`OFF_PERIPH_CONFIG, 32'h00000005);
      pwm_en <= 1'b1;
      pwm_bcd <= 3'b010;
      settle();
      chk(32'(d_out[7:5]), 32'h2);
      // Reverse full bridge owns the same three pins
      wr(`OFF_PERIPH_CONFIG, 32'h00000007);
      settle();
      chk(32'(d_out[7:5]), 32'h2);
      wr(`OFF_PERIPH_CONFIG, 32'h00000003);
      pwm_bcd <= 3'b111;
      settle();
      chk(32'(d_out[7:5]), 32'h5);
      // Parallel slave port, blocked by dual output PWM
      wr(`OFF_PORT_E_DIRECTION, 32'h00000017);
      psp_rd <= 8'h5C;
      psp_oe <= 1'b1;
      settle();
      chk(32'(psp_act), 32'h0);
      chk(32'({d_oe[4:0], d_out[4:0]}), 32'h3F6);
      wr(`OFF_PERIPH_CONFIG, 32'h00000001);
      settle();
      chk(32'({psp_act, ttl}), 32'h3);
      chk(32'({d_oe, d_out}), 32'hFF5C);
      // Second channel drives port C bit 1, then moves to port B bit 3
      @(posedge i_clk);
      pwm_en <= 1'b0;
      ch2_out <= 1'b1;
      ch2_oe <= 1'b1;
      settle();
      chk(32'({on_c1, c_oe[1], c_out[1], b3_oe}), 32'hE);
      wr(`OFF_PERIPH_CONFIG, 32'h00000000);
      settle();
      chk(32'({on_c1, c_oe[1], b3_out, b3_oe}), 32'h3);
      // Unmapped place: write then read, only the read is checked for zero data and error
      wr(12'h020, 32'h000000FF);
      rc(12'h020, 32'h0, 1'b1);
      wrap_up();
   end
endmodule // port_cd_io_bench
`default_nettype wire
